// [psc_host_model.sv]
// I2C controller model standing in for the host processor.
// Assumes SDA is an open-drain wire whose pull-up level the bench resolves.
`timescale 1ns/100ps
module psc_host_model #(
  parameter int HALF = 8
) (
  input wire logic i_ref_clk,
  input wire logic i_sda_wire,
  output logic o_scl,
  output logic o_sda_low
);
  // Idle bus with both lines released
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end
  // Whole clocks, then just past the edge
  task automatic tick(input int n);
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask
  // Start or repeated start, SDA falls with SCL high
  task automatic start_cond();
    o_sda_low = 1'b0;
    tick(HALF);
    o_scl = 1'b1;
    tick(HALF);
    o_sda_low = 1'b1;
    tick(HALF);
    o_scl = 1'b0;
  endtask
  // Stop, SDA rises with SCL high
  task automatic stop_cond();
    tick(HALF / 2);
    o_sda_low = 1'b1;
    tick(HALF / 2);
    o_scl = 1'b1;
    tick(HALF);
    o_sda_low = 1'b0;
    tick(HALF);
  endtask
  // One bit, set mid-low, sampled late in the high phase
  task automatic bit_io(input logic b, output logic r);
    tick(HALF / 2);
    o_sda_low = ~b;
    tick(HALF / 2);
    o_scl = 1'b1;
    tick(HALF);
    r = i_sda_wire;
    o_scl = 1'b0;
  endtask
  // Byte MSB first, then the acknowledge bit
  task automatic byte_io(input logic [7:0] d, input logic ack_in, output logic [7:0] q,
                         output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
      q[i] = r;
    end
    bit_io(ack_in, r);
    ack = ~r;
  endtask
endmodule

// [psc_pkg.sv]
// Constants, field layouts and types for the power sequencer slot configuration.
// Assumes a single 250 MHz clock and a host reaching the registers over I2C.
package psc_pkg;
  // I2C target address and register map
  localparam logic [6:0] I2C_TARGET_ADDR = 7'h3c;
  localparam logic [7:0] MASTER_CFG_FIRST = 8'h43;
  localparam logic [7:0] MASTER_CFG_LAST = 8'h45;
  localparam logic [7:0] SLAVE_CFG_FIRST = 8'h46;
  localparam logic [7:0] SLAVE_CFG_LAST = 8'h57;
  localparam int NUM_SLAVES = 18;
  localparam int NUM_MASTERS = 3;
  // Slave register fields
  localparam int SRC_MSB = 7;
  localparam int SRC_LSB = 6;
  localparam int PU_MSB = 5;
  localparam int PU_LSB = 3;
  localparam int PD_MSB = 2;
  localparam int PD_LSB = 0;
  localparam logic [1:0] SRC_UNASSIGNED = 2'h3;
  // Master register fields (bits 7:6 reserved, read as zero)
  localparam int PERIOD_MSB = 5;
  localparam int PERIOD_LSB = 3;
  localparam int ESRC_MSB = 2;
  localparam int ESRC_LSB = 1;
  localparam int SOFT_EN_BIT = 0;
  localparam int MASTER_CFG_W = 6;
  localparam logic [1:0] ESRC_FIRST = 2'h0;
  localparam logic [1:0] ESRC_SECOND = 2'h1;
  localparam logic [1:0] ESRC_SOFT = 2'h2;
  localparam logic [2:0] LAST_SLOT = 3'h7;
  // Slave index layout of the outputs
  localparam int LIN_FIRST = 0;
  localparam int LIN_COUNT = 9;
  localparam int BUCK_FIRST = 9;
  localparam int BUCK_COUNT = 5;
  localparam int GPIO_FIRST = 14;
  localparam int GPIO_COUNT = 3;
  localparam int RESET_IDX = 17;
  // Reset values before the first shutdown reload
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [4:0] SYNC_RST = 5'h13;
  // Slot timer base period
  localparam int SLOT_BASE_US = 40;
  localparam int CLK_MHZ = 250;
  localparam int SLOT_BASE_CYCLES = SLOT_BASE_US * CLK_MHZ;
  localparam int TMR_W = 24;
  // I2C target states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_REG = 3'b010,
    ST_WRITE = 3'b011,
    ST_READ = 3'b100,
    ST_RACK = 3'b101
  } psc_i2c_state_t;
endpackage

// [psc_sequencer.sv]
// I2C-reached slot configuration and three sequencer masters driving 18 outputs.
// Assumes i_global_shutdown and power-mode inputs are same-clock logic; pins are async.
`timescale 1ns/100ps
module psc_sequencer #(
  parameter int SLOT_BASE_CYCLES = psc_pkg::SLOT_BASE_CYCLES
) (
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_out,
  output logic o_sda_oe,
  input wire logic i_global_shutdown,
  input wire logic [psc_pkg::NUM_SLAVES*8-1:0] i_otp_slave_cfg,
  input wire logic [psc_pkg::NUM_MASTERS*psc_pkg::MASTER_CFG_W-1:0] i_otp_master_cfg,
  input wire logic i_hw_enable_input_zero,
  input wire logic i_hw_enable_input_one,
  input wire logic [psc_pkg::LIN_COUNT-1:0] i_linear_reg_power_mode,
  input wire logic [psc_pkg::BUCK_COUNT-1:0] i_buck_power_mode,
  input wire logic [psc_pkg::GPIO_COUNT-1:0] i_gpio_output_level,
  input wire logic i_reset_in_out_pin,
  output logic [psc_pkg::NUM_SLAVES-1:0] o_output_enable
);
  localparam int NS = psc_pkg::NUM_SLAVES;
  localparam int NM = psc_pkg::NUM_MASTERS;
  localparam int TW = psc_pkg::TMR_W;
  localparam logic [TW-1:0] BASE = TW'(SLOT_BASE_CYCLES);

  function automatic logic in_range(input logic [7:0] a, input logic [7:0] lo,
                                    input logic [7:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction

  function automatic logic [TW-1:0] reload(input logic [2:0] code);
    reload = (BASE << code) - TW'(1);
  endfunction

  function automatic logic slot_on(input logic up, input logic [2:0] slot,
                                   input logic [2:0] pu, input logic [2:0] pd);
    slot_on = up ? (slot >= pu) : (slot < pd);
  endfunction

  // Pin synchronisers: bit 0 scl, 1 sda, 2 hw0, 3 hw1, 4 reset pin
  logic [4:0] s1_r, s2_r, s3_r, filt_r, filt_d_r, filt_nxt;
  always_comb begin
    for (int b = 0; b < 5; b++) begin
      filt_nxt[b] = (s2_r[b] == s3_r[b]) ? s3_r[b] : filt_r[b];
    end
  end
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      s1_r <= psc_pkg::SYNC_RST;
      s2_r <= psc_pkg::SYNC_RST;
      s3_r <= psc_pkg::SYNC_RST;
      filt_r <= psc_pkg::SYNC_RST;
      filt_d_r <= psc_pkg::SYNC_RST;
    end else begin
      s1_r <= {i_reset_in_out_pin, i_hw_enable_input_one, i_hw_enable_input_zero, i_sda, i_scl};
      s2_r <= s1_r;
      s3_r <= s2_r;
      filt_r <= filt_nxt;
      filt_d_r <= filt_r;
    end
  end

  logic scl_rise, scl_fall, bus_start, bus_stop, sda_in;
  assign sda_in = filt_r[1];
  assign scl_rise = filt_r[0] & ~filt_d_r[0];
  assign scl_fall = ~filt_r[0] & filt_d_r[0];
  assign bus_start = filt_r[0] & filt_d_r[0] & ~filt_r[1] & filt_d_r[1];
  assign bus_stop = filt_r[0] & filt_d_r[0] & filt_r[1] & ~filt_d_r[1];

  // Register file access
  psc_pkg::psc_i2c_state_t st_r, st_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [7:0] sh_r, sh_nxt, ptr_r, ptr_nxt, rd_mux, mem_rd;
  logic ack_r, ack_nxt, rw_r, rw_nxt, oe_r, oe_nxt, mack_r, mack_nxt, wr_en;
  logic [5:0] mcfg_r [NM];
  logic [NS*8-1:0] slave_all;
  logic mem_wr, slave_hit, master_hit;
  logic [4:0] slave_idx;
  logic [1:0] master_idx;

  assign slave_hit = in_range(ptr_r, psc_pkg::SLAVE_CFG_FIRST, psc_pkg::SLAVE_CFG_LAST);
  assign master_hit = in_range(ptr_r, psc_pkg::MASTER_CFG_FIRST, psc_pkg::MASTER_CFG_LAST);
  assign slave_idx = 5'(ptr_r - psc_pkg::SLAVE_CFG_FIRST);
  assign master_idx = 2'(ptr_r - psc_pkg::MASTER_CFG_FIRST);
  assign mem_wr = wr_en & slave_hit;

  // Read data: reserved master bits and unmapped addresses read zero
  always_comb begin
    if (master_hit) begin
      rd_mux = {2'h0, mcfg_r[master_idx]};
    end else if (slave_hit) begin
      rd_mux = mem_rd;
    end else begin
      rd_mux = 8'h00;
    end
  end

  psc_slot_mem #(.N(NS), .W(8), .AW(5)) u_mem (
    .i_ref_clk(i_ref_clk),
    .i_resetn(i_resetn),
    .i_load(i_global_shutdown),
    .i_load_data(i_otp_slave_cfg),
    .i_wr_en(mem_wr),
    .i_wr_idx(slave_idx),
    .i_wr_data(sh_r),
    .i_rd_idx(slave_idx),
    .o_rd_data(mem_rd),
    .o_all(slave_all)
  );

  // I2C target: bits sampled on scl rise, sda changed on scl fall
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    sh_nxt = sh_r;
    ptr_nxt = ptr_r;
    ack_nxt = ack_r;
    rw_nxt = rw_r;
    oe_nxt = oe_r;
    mack_nxt = mack_r;
    wr_en = 1'b0;
    if (bus_start) begin
      st_nxt = psc_pkg::ST_ADDR;
      cnt_nxt = 4'h0;
      ack_nxt = 1'b0;
      oe_nxt = 1'b0;
    end else if (bus_stop) begin
      st_nxt = psc_pkg::ST_IDLE;
      ack_nxt = 1'b0;
      oe_nxt = 1'b0;
    end else if (st_r != psc_pkg::ST_IDLE) begin
      if (scl_rise) begin
        if (st_r == psc_pkg::ST_RACK) begin
          mack_nxt = ~sda_in;
        end else if (st_r == psc_pkg::ST_READ) begin
          cnt_nxt = cnt_r + 4'h1;
        end else if (!ack_r) begin
          sh_nxt = {sh_r[6:0], sda_in};
          cnt_nxt = cnt_r + 4'h1;
        end
      end else if (scl_fall) begin
        if (ack_r) begin
          ack_nxt = 1'b0;
          oe_nxt = 1'b0;
          cnt_nxt = 4'h0;
          if (st_r == psc_pkg::ST_ADDR && rw_r) begin
            st_nxt = psc_pkg::ST_READ;
            sh_nxt = rd_mux;
            oe_nxt = ~rd_mux[7];
          end else if (st_r == psc_pkg::ST_ADDR) begin
            st_nxt = psc_pkg::ST_REG;
          end else if (st_r == psc_pkg::ST_REG) begin
            st_nxt = psc_pkg::ST_WRITE;
          end
        end else if (st_r == psc_pkg::ST_READ) begin
          if (cnt_r == 4'h8) begin
            oe_nxt = 1'b0;
            st_nxt = psc_pkg::ST_RACK;
            ptr_nxt = ptr_r + 8'h01;
          end else begin
            sh_nxt = {sh_r[6:0], 1'b0};
            oe_nxt = ~sh_r[6];
          end
        end else if (st_r == psc_pkg::ST_RACK) begin
          if (mack_r) begin
            st_nxt = psc_pkg::ST_READ;
            sh_nxt = rd_mux;
            oe_nxt = ~rd_mux[7];
            cnt_nxt = 4'h0;
          end else begin
            st_nxt = psc_pkg::ST_IDLE;
          end
        end else if (cnt_r == 4'h8) begin
          ack_nxt = 1'b1;
          oe_nxt = 1'b1;
          if (st_r == psc_pkg::ST_ADDR) begin
            rw_nxt = sh_r[0];
            if (sh_r[7:1] != psc_pkg::I2C_TARGET_ADDR) begin
              st_nxt = psc_pkg::ST_IDLE;
              ack_nxt = 1'b0;
              oe_nxt = 1'b0;
            end
          end else if (st_r == psc_pkg::ST_REG) begin
            ptr_nxt = sh_r;
          end else begin
            wr_en = 1'b1;
            ptr_nxt = ptr_r + 8'h01;
          end
        end
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st_r <= psc_pkg::ST_IDLE;
      cnt_r <= 4'h0;
      sh_r <= 8'h00;
      ptr_r <= 8'h00;
      ack_r <= 1'b0;
      rw_r <= 1'b0;
      oe_r <= 1'b0;
      mack_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      sh_r <= sh_nxt;
      ptr_r <= ptr_nxt;
      ack_r <= ack_nxt;
      rw_r <= rw_nxt;
      oe_r <= oe_nxt;
      mack_r <= mack_nxt;
    end
  end

  assign o_sda_out = 1'b0;
  assign o_sda_oe = oe_r;

  // Sequencer masters: configuration, enable source and slot timers
  logic [5:0] mcfg_nxt [NM];
  logic up_r [NM], up_nxt [NM], en_d_r [NM], m_en [NM];
  logic [2:0] slot_r [NM], slot_nxt [NM];
  logic [TW-1:0] tmr_r [NM], tmr_nxt [NM];
  always_comb begin
    for (int m = 0; m < 2; m++) begin
      case (mcfg_r[m][psc_pkg::ESRC_MSB:psc_pkg::ESRC_LSB])
        psc_pkg::ESRC_FIRST: m_en[m] = filt_r[2];
        psc_pkg::ESRC_SECOND: m_en[m] = filt_r[3];
        psc_pkg::ESRC_SOFT: m_en[m] = mcfg_r[m][psc_pkg::SOFT_EN_BIT];
        default: m_en[m] = 1'b0;
      endcase
    end
    case (mcfg_r[2][psc_pkg::ESRC_MSB:psc_pkg::ESRC_LSB])
      psc_pkg::ESRC_FIRST: m_en[2] = m_en[0];
      psc_pkg::ESRC_SECOND: m_en[2] = m_en[1];
      psc_pkg::ESRC_SOFT: m_en[2] = mcfg_r[2][psc_pkg::SOFT_EN_BIT];
      default: m_en[2] = 1'b0;
    endcase
    for (int m = 0; m < NM; m++) begin
      mcfg_nxt[m] = mcfg_r[m];
      up_nxt[m] = up_r[m];
      slot_nxt[m] = slot_r[m];
      tmr_nxt[m] = tmr_r[m];
      if (i_global_shutdown) begin
        mcfg_nxt[m] = i_otp_master_cfg[m*6 +: 6];
      end else if (wr_en && master_hit && master_idx == 2'(m)) begin
        mcfg_nxt[m] = sh_r[5:0];
      end
      if (m_en[m] != en_d_r[m]) begin
        up_nxt[m] = m_en[m];
        slot_nxt[m] = 3'h0;
        tmr_nxt[m] = reload(mcfg_r[m][psc_pkg::PERIOD_MSB:psc_pkg::PERIOD_LSB]);
      end else if (slot_r[m] != psc_pkg::LAST_SLOT) begin
        if (tmr_r[m] == '0) begin
          slot_nxt[m] = slot_r[m] + 3'h1;
          tmr_nxt[m] = reload(mcfg_r[m][psc_pkg::PERIOD_MSB:psc_pkg::PERIOD_LSB]);
        end else begin
          tmr_nxt[m] = tmr_r[m] - TW'(1);
        end
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      for (int m = 0; m < NM; m++) begin
        mcfg_r[m] <= 6'h00;
        up_r[m] <= 1'b0;
        en_d_r[m] <= 1'b0;
        slot_r[m] <= psc_pkg::LAST_SLOT;
        tmr_r[m] <= '0;
      end
    end else begin
      for (int m = 0; m < NM; m++) begin
        mcfg_r[m] <= mcfg_nxt[m];
        up_r[m] <= up_nxt[m];
        en_d_r[m] <= m_en[m];
        slot_r[m] <= slot_nxt[m];
        tmr_r[m] <= tmr_nxt[m];
      end
    end
  end

  // Output enables: sequenced by a master, or own source when unassigned
  logic [NS-1:0] local_en, out_r, out_nxt;
  assign local_en = {filt_r[4], i_gpio_output_level, i_buck_power_mode, i_linear_reg_power_mode};
  always_comb begin
    for (int k = 0; k < NS; k++) begin
      logic [7:0] c;
      c = slave_all[k*8 +: 8];
      if (c[psc_pkg::SRC_MSB:psc_pkg::SRC_LSB] == psc_pkg::SRC_UNASSIGNED) begin
        out_nxt[k] = local_en[k];
      end else begin
        out_nxt[k] = slot_on(up_r[c[psc_pkg::SRC_MSB:psc_pkg::SRC_LSB]],
                             slot_r[c[psc_pkg::SRC_MSB:psc_pkg::SRC_LSB]],
                             c[psc_pkg::PU_MSB:psc_pkg::PU_LSB], c[psc_pkg::PD_MSB:psc_pkg::PD_LSB]);
      end
    end
  end
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      out_r <= '0;
    end else begin
      out_r <= out_nxt;
    end
  end
  assign o_output_enable = out_r;

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_resetn);

  property p_lin_local;
    slave_all[71:70] == 2'h3 |=> o_output_enable[8] == $past(i_linear_reg_power_mode[8]);
  endproperty
  a_lin_local: assert property (p_lin_local) else $error("linear not local");
  property p_buck_local;
    slave_all[87:86] == 2'h3 |=> o_output_enable[10] == $past(i_buck_power_mode[1]);
  endproperty
  a_buck_local: assert property (p_buck_local) else $error("buck not local");
  property p_rst_pass;
    slave_all[143:142] == 2'h3 |=> o_output_enable[17] == $past(filt_r[4]);
  endproperty
  a_rst_pass: assert property (p_rst_pass) else $error("reset not passed");
  property p_gpio_free;
    (slave_all[119:118] == 2'h3 && $stable(i_gpio_output_level[0])) [*3] |->
      $stable(o_output_enable[14]);
  endproperty
  a_gpio_free: assert property (p_gpio_free) else $error("unassigned moved");
  sequence s_m0_up_reached;
    slave_all[7:6] == 2'h0 && up_r[0] && slot_r[0] >= slave_all[5:3];
  endsequence
  property p_up_on;
    s_m0_up_reached |=> o_output_enable[0];
  endproperty
  a_up_on: assert property (p_up_on) else $error("power-up slot missed");
  property p_down_off;
    slave_all[79:78] == 2'h1 && !up_r[1] && slot_r[1] >= slave_all[74:72] |=> !o_output_enable[9];
  endproperty
  a_down_off: assert property (p_down_off) else $error("power-down slot missed");
  property p_soft_ignored;
    mcfg_r[1][2:1] == 2'h0 |-> m_en[1] == filt_r[2];
  endproperty
  a_soft_ignored: assert property (p_soft_ignored) else $error("soft enable leaked");
  property p_follow;
    mcfg_r[2][2:1] == 2'h0 |-> m_en[2] == m_en[0];
  endproperty
  a_follow: assert property (p_follow) else $error("master two not following");
  property p_slot_step;
    (slot_r[0] != 3'h7 && tmr_r[0] == '0 && m_en[0] == en_d_r[0]) |=> slot_r[0] == $past(slot_r[0]) + 3'h1;
  endproperty
  a_slot_step: assert property (p_slot_step) else $error("slot did not step");
endmodule

// [psc_slot_mem.sv]
// Storage for the eighteen slave configuration bytes.
// Assumes write and reload strobes from the same clock domain.
`timescale 1ns/100ps
module psc_slot_mem #(
  parameter int N = 18,
  parameter int W = 8,
  parameter int AW = 5
) (
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  input wire logic i_load,
  input wire logic [N*W-1:0] i_load_data,
  input wire logic i_wr_en,
  input wire logic [AW-1:0] i_wr_idx,
  input wire logic [W-1:0] i_wr_data,
  input wire logic [AW-1:0] i_rd_idx,
  output logic [W-1:0] o_rd_data,
  output logic [N*W-1:0] o_all
);
  logic [W-1:0] mem_r [N];
  logic [W-1:0] mem_nxt [N];
  logic [W-1:0] rd_r;
  logic [W-1:0] rd_nxt;

  // Next contents: reload wins over a host write
  always_comb begin
    for (int k = 0; k < N; k++) begin
      mem_nxt[k] = mem_r[k];
      o_all[k*W +: W] = mem_r[k];
      if (i_load) begin
        mem_nxt[k] = i_load_data[k*W +: W];
      end else if (i_wr_en && (i_wr_idx == AW'(k))) begin
        mem_nxt[k] = i_wr_data;
      end
    end
    rd_nxt = (i_rd_idx < AW'(N)) ? mem_r[i_rd_idx] : '0;
  end

  // Register the array and the read port
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      for (int k = 0; k < N; k++) begin
        mem_r[k] <= psc_pkg::CFG_RST;
      end
      rd_r <= '0;
    end else begin
      for (int k = 0; k < N; k++) begin
        mem_r[k] <= mem_nxt[k];
      end
      rd_r <= rd_nxt;
    end
  end

  assign o_rd_data = rd_r;

  property p_reload_all;
    @(posedge i_ref_clk) disable iff (!i_resetn)
    i_load |=> (o_all == $past(i_load_data));
  endproperty
  a_reload_all: assert property (p_reload_all) else $error("reload missed");

  property p_write_reads;
    @(posedge i_ref_clk) disable iff (!i_resetn)
    (i_wr_en && !i_load && i_wr_idx < AW'(N)) |=> (o_all[$past(i_wr_idx)*W +: W] == $past(i_wr_data));
  endproperty
  a_write_reads: assert property (p_write_reads) else $error("write lost");
endmodule

// [testbench.sv]
// Self-checking bench for the slot configuration block driven by an I2C host model.
// Assumes a slot base of 4 clocks so that sequences stay short.
`timescale 1ns/100ps
module testbench;
  localparam int BASE = 4;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic shutdown = 1'b0;
  logic [143:0] otp_slave = '0;
  logic [17:0] otp_master = '0;
  logic hw0 = 1'b0;
  logic hw1 = 1'b0;
  logic [8:0] lin_mode = '0;
  logic [4:0] buck_mode = '0;
  logic rst_pin = 1'b0;
  logic [2:0] gpio_lvl = 3'h5;
  logic scl, host_low, sda_out, sda_oe, sda_wire;
  logic [17:0] oe, oe_d;
  logic [7:0] exp_reg [0:255];
  int rise_t [0:17];
  int fall_t [0:17];
  int cyc = 0;
  int err_total = 0;
  int n_checks = 0;
  integer seed = 32'hf3d9534f;
  // Clock and open-drain wire
  always #2 clk = ~clk;
  assign sda_wire = !(host_low || (sda_oe && !sda_out));
  psc_sequencer #(.SLOT_BASE_CYCLES(BASE)) dut (.i_ref_clk(clk), .i_resetn(resetn),
    .i_scl(scl), .i_sda(sda_wire), .o_sda_out(sda_out), .o_sda_oe(sda_oe),
    .i_global_shutdown(shutdown), .i_otp_slave_cfg(otp_slave), .i_otp_master_cfg(otp_master),
    .i_hw_enable_input_zero(hw0), .i_hw_enable_input_one(hw1),
    .i_linear_reg_power_mode(lin_mode), .i_buck_power_mode(buck_mode),
    .i_gpio_output_level(gpio_lvl), .i_reset_in_out_pin(rst_pin), .o_output_enable(oe));
  psc_host_model host (.i_ref_clk(clk), .i_sda_wire(sda_wire), .o_scl(scl),
    .o_sda_low(host_low));
  // Time stamps of output edges
  always @(posedge clk) begin
    cyc <= cyc + 1;
    oe_d <= oe;
    for (int k = 0; k < 18; k++) begin
      if (oe[k] && !oe_d[k])
        rise_t[k] <= cyc;
      if (!oe[k] && oe_d[k])
        fall_t[k] <= cyc;
    end
  end
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", name, exp, got);
      err_total++;
    end
  endtask
  task automatic results();
    $display("Checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Burst write, mirrored into the reference map
  task automatic wr_burst(input logic [7:0] ra, input logic [7:0] q [$]);
    logic [7:0] d;
    logic ack;
    int a;
    host.start_cond();
    host.byte_io({psc_pkg::I2C_TARGET_ADDR, 1'b0}, 1'b1, d, ack);
    chk("addr ack", 1, 32'(ack));
    host.byte_io(ra, 1'b1, d, ack);
    foreach (q[i]) begin
      host.byte_io(q[i], 1'b1, d, ack);
      chk("data ack", 1, 32'(ack));
      a = ra + i;
      if (a >= 'h43 && a <= 'h45)
        exp_reg[a] = {2'b00, q[i][5:0]};
      else if (a >= 'h46 && a <= 'h57)
        exp_reg[a] = q[i];
    end
    host.stop_cond();
  endtask
  task automatic wr1(input logic [7:0] ra, input logic [7:0] v);
    logic [7:0] q [$];
    q.push_back(v);
    wr_burst(ra, q);
  endtask
  // Burst read compared with the reference map
  task automatic rd_burst(input logic [7:0] ra, input int n);
    logic [7:0] d;
    logic ack;
    host.start_cond();
    host.byte_io({psc_pkg::I2C_TARGET_ADDR, 1'b0}, 1'b1, d, ack);
    host.byte_io(ra, 1'b1, d, ack);
    host.start_cond();
    host.byte_io({psc_pkg::I2C_TARGET_ADDR, 1'b1}, 1'b1, d, ack);
    for (int i = 0; i < n; i++) begin
      host.byte_io(8'hff, i == n - 1, d, ack);
      chk("read data", 32'(exp_reg[ra + i]), 32'(d));
    end
    host.stop_cond();
  endtask
  // Hang guard
  initial begin
    repeat (100000) @(posedge clk);
    $display("ERROR watchdog expected finish seen hang");
    err_total++;
    results();
  end
  // Main sequence
  initial begin
    logic [7:0] q [$];
    logic [7:0] d;
    logic ack;
    for (int a = 0; a < 256; a++)
      exp_reg[a] = 8'h00;
    for (int k = 0; k < 18; k++)
      otp_slave[8*k +: 8] = 8'($random(seed));
    otp_master = 18'($random(seed));
    repeat (20) @(posedge clk);
    chk("reset outputs", 0, 32'(oe));
    #1;
    resetn = 1'b1;
    step(1);
    shutdown = 1'b1;
    step(1);
    shutdown = 1'b0;
    for (int k = 0; k < 18; k++)
      exp_reg['h46 + k] = otp_slave[8*k +: 8];
    for (int m = 0; m < 3; m++)
      exp_reg['h43 + m] = {2'b00, otp_master[6*m +: 6]};
    step(5);
    rd_burst(8'h43, 21);
    $display("Test otp reload done");
    for (int k = 0; k < 19; k++)
      q.push_back(8'($random(seed)));
    wr_burst(8'h46, q);
    rd_burst(8'h46, 19);
    host.start_cond();
    host.byte_io(8'h7a, 1'b1, d, ack);
    chk("foreign addr ack", 0, 32'(ack));
    host.stop_cond();
    $display("Test register map done");
    // Master 0 period code 1, master 2 follows master 0
    q = {8'h0c, 8'h01, 8'h00};
    for (int k = 0; k < 8; k++)
      q.push_back({2'b00, 3'(k), 3'(7 - k)});
    q.push_back(8'hc0);
    q.push_back(8'h40);
    repeat (4) q.push_back(8'hc0);
    for (int j = 0; j < 3; j++)
      q.push_back({2'b10, 3'(j), 3'(j)});
    q.push_back(8'hc0);
    wr_burst(8'h43, q);
    chk("idle m0 m2", 0, 32'({oe[16:14], oe[7:0]}));
    wr1(8'h43, 8'h0d);
    step(120);
    chk("all up", 32'h7ff, 32'({oe[16:14], oe[7:0]}));
    for (int k = 1; k < 8; k++)
      chk("m0 up slot", k * 2 * BASE, rise_t[k] - rise_t[0]);
    for (int j = 1; j < 3; j++)
      chk("m2 up slot", j * BASE, rise_t[14 + j] - rise_t[14]);
    // Unassigned outputs follow their own sources
    repeat (3) begin
      lin_mode = 9'($random(seed));
      buck_mode = 5'($random(seed));
      rst_pin = 1'($random(seed));
      gpio_lvl = 3'($random(seed));
      step(12);
      chk("linear own", 32'(lin_mode[8]), 32'(oe[8]));
      chk("buck own", 32'(buck_mode[4:1]), 32'(oe[13:10]));
      chk("reset pin", 32'(rst_pin), 32'(oe[17]));
      chk("soft ignored", 0, 32'(oe[9]));
      chk("gpio sequenced", 32'h7, 32'(oe[16:14]));
    end
    $display("Test power up done");
    hw0 = 1'b1;
    step(20);
    chk("m1 hw zero", 1, 32'(oe[9]));
    wr1(8'h44, 8'h07);
    chk("m1 reserved", 0, 32'(oe[9]));
    wr1(8'h45, 8'h02);
    step(20);
    chk("m2 follows m1 off", 0, 32'(oe[16:14]));
    hw1 = 1'b1;
    wr1(8'h44, 8'h02);
    step(20);
    chk("m1 hw one", 1, 32'(oe[9]));
    chk("m2 follows m1 on", 32'h7, 32'(oe[16:14]));
    wr1(8'h45, 8'h00);
    wr1(8'h43, 8'h0c);
    step(120);
    chk("all down", 0, 32'({oe[16:14], oe[7:0]}));
    for (int k = 0; k < 7; k++)
      chk("m0 down slot", (7 - k) * 2 * BASE, fall_t[k] - fall_t[7]);
    for (int j = 1; j < 3; j++)
      chk("m2 down slot", j * BASE, fall_t[14 + j] - fall_t[14]);
    $display("Test power down done");
    results();
  end
endmodule
